// *** rtl/adcro_readout.v ***
// Converter read-out port: clock re-timer and parallel byte protocols
//
// Functional notes
// - Retimed modes drive data lanes plus an accompanying strobe clock.
// - SDR data changes on strobe rising edges; MSB at first rising edge.
// - Retimer source field picks host serial clock or internal oscillator.
// - In retimed modes, lanes not enabled by lane count stay high impedance; byte modes drive all eight.
// - Protocol field 010b selects retimed SDR, 011b retimed DDR.
// - Retimed SDR uses one, two or four lanes.
// - Retimed DDR uses one, two or four lanes, launching both edges.
// - Overhead is chip-select timing, or select-to-strobe delay internally.
// - Retimed reads deliver converter A's 16-bit word; byte reads deliver both converters' words.
// - Byte modes put each converter's result on all lanes as bytes.
// - Byte modes accept every clock polarity and phase.
// - Byte arrangement follows format field: AB or AA.
// - Byte modes are single data rate only.
// - Protocol field pattern 1xxb selects byte output.
// - Byte word read completes in 3.5 serial clock periods for variants 00/10, 4 for 01/11.
// - Byte variants 00/10 launch at select fall; 01/11 at first clock edge.
// - After reset, configuration uses polarity 0 phase 0 single lane.
`timescale 1ns/100ps
`include "adcro_defs.vh"
module adcro_readout #(
  parameter [7:0] OSC_DIV = `ADCRO_OSC_DIV
) (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        cs_n_pin,
  input  wire        sclk_pin,
  input  wire        sdi_pin,
  input  wire [15:0] result_a,
  input  wire [15:0] result_b,
  output reg  [7:0]  data_out_lane_a,
  output reg  [7:0]  data_out_lane_a_oe,
  output reg         strobe_out,
  output reg  [2:0]  output_protocol_sel,
  output reg  [1:0]  lane_count_sel,
  output reg         retimer_clock_source_sel,
  output reg         clock_polarity_bit,
  output reg         clock_phase_bit,
  output reg         byte_format_sel,
  output reg         read_busy
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RUN  = 4'b0010;
  localparam [3:0] ST_DONE = 4'b0100;
  localparam [3:0] ST_CFG  = 4'b1000;

  wire cs_n_s;
  wire sclk_s;
  wire sdi_s;
  wire osc_tick;
  reg  sclk_d_reg;
  reg  cs_n_d_reg;
  reg  [3:0]  state_reg;
  reg  [31:0] shift_reg;
  reg  [5:0]  bit_cnt_reg;
  reg  [15:0] cmd_reg;
  reg  [4:0]  cmd_cnt_reg;
  reg         strobe_reg;
  reg         first_reg;
  reg  [2:0]  lanes;
  reg  [5:0]  total_bits;
  reg         is_crt;
  reg         is_pb;
  reg         ext_src;
  reg         rise_ev;
  reg         fall_ev;
  reg         shift_ev;
  reg         sample_ev;
  reg  [7:0]  oe_next;
  reg  [31:0] pb_word;
  wire        cs_fall = cs_n_d_reg & ~cs_n_s;
  wire        cs_rise = ~cs_n_d_reg & cs_n_s;
  wire        sclk_rise = ~sclk_d_reg & sclk_s;
  wire        sclk_fall = sclk_d_reg & ~sclk_s;

  adcro_sync2 u_sync_cs (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .pin_in   (cs_n_pin),
    .pin_sync (cs_n_s)
  );

  adcro_sync2 u_sync_sclk (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .pin_in   (sclk_pin),
    .pin_sync (sclk_s)
  );

  adcro_sync2 u_sync_sdi (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .pin_in   (sdi_pin),
    .pin_sync (sdi_s)
  );

  adcro_osc_div #(.DIV(OSC_DIV)) u_osc (
    .clk_sys (clk_sys),
    .reset   (reset),
    .run     (is_crt && !ext_src && state_reg == ST_RUN),
    .tick    (osc_tick)
  );

  always @* begin
    pb_word = pb_pack(result_a, result_b, byte_format_sel);
    // retimed single and double rate codes
    is_crt  = output_protocol_sel == `ADCRO_PROTO_CRT_SDR ||
              output_protocol_sel == `ADCRO_PROTO_CRT_DDR;
    is_pb   = output_protocol_sel[`ADCRO_PROTO_PB_BIT];
    ext_src = retimer_clock_source_sel == `ADCRO_CRT_SRC_EXT;
    case (lane_count_sel)
      `ADCRO_LANES_TWO:  lanes = 3'd2;
      `ADCRO_LANES_FOUR: lanes = 3'd4;
      default:           lanes = 3'd1;
    endcase
    // two words on all lanes in byte mode
    total_bits = is_pb ? 6'd32 : 6'd16;
    // external strobe assumes serial clock idles low
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    if (is_crt) begin
      if (ext_src) begin
        rise_ev = sclk_rise;
        fall_ev = sclk_fall;
      end else begin
        rise_ev = osc_tick & ~strobe_reg;
        fall_ev = osc_tick & strobe_reg;
      end
    end
    // launch edges; DDR also on falling
    shift_ev  = 1'b0;
    sample_ev = 1'b0;
    if (is_crt) begin
      shift_ev = rise_ev ||
                 (output_protocol_sel == `ADCRO_PROTO_CRT_DDR && fall_ev);
    end else if (is_pb) begin
      // launch edge from polarity and phase, single rate
      if (clock_polarity_bit ^ clock_phase_bit)
        shift_ev = sclk_rise;
      else
        shift_ev = sclk_fall;
      sample_ev = shift_ev;
    end
    oe_next = 8'h00;
    if (is_pb)
      oe_next = 8'hff;
    else if (is_crt) begin
      case (lanes)
        3'd2:    oe_next = 8'h03;
        3'd4:    oe_next = 8'h0f;
        default: oe_next = 8'h01;
      endcase
    end
  end

  function [31:0] pb_pack;
    input [15:0] a;
    input [15:0] b;
    input        fmt;
    begin
      if (fmt == `ADCRO_FMT_AA)
        pb_pack = {a, b};
      else
        pb_pack = {a[15:8], b[15:8], a[7:0], b[7:0]};
    end
  endfunction

  always @(posedge clk_sys) begin
    if (reset) begin
      sclk_d_reg  <= 1'b0;
      // Matches synchroniser reset level: no false select fall
      cs_n_d_reg  <= 1'b0;
      state_reg   <= ST_IDLE;
      shift_reg   <= 32'h0000_0000;
      bit_cnt_reg <= 6'h00;
      cmd_reg     <= 16'h0000;
      cmd_cnt_reg <= 5'h00;
      strobe_reg  <= 1'b0;
      first_reg   <= 1'b0;
      strobe_out  <= 1'b0;
      read_busy   <= 1'b0;
      data_out_lane_a    <= 8'h00;
      data_out_lane_a_oe <= 8'h00;
      // reset to single lane, polarity 0 phase 0
      output_protocol_sel      <= `ADCRO_PROTO_SPI_SDR;
      lane_count_sel           <= `ADCRO_LANES_ONE;
      retimer_clock_source_sel <= `ADCRO_CRT_SRC_EXT;
      clock_polarity_bit       <= 1'b0;
      clock_phase_bit          <= 1'b0;
      byte_format_sel          <= `ADCRO_FMT_AB;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_n_d_reg <= cs_n_s;
      case (state_reg)
        ST_IDLE: begin
          if (cs_fall) begin
            read_busy   <= 1'b1;
            bit_cnt_reg <= 6'h00;
            cmd_cnt_reg <= 5'h00;
            first_reg   <= 1'b1;
            if (is_crt || is_pb) begin
              shift_reg <= is_pb ? pb_word : {result_a, 16'h0000};
              data_out_lane_a_oe <= oe_next;
              state_reg <= ST_RUN;
              // variants 00/10 launch first byte at select fall
              if (is_pb && !clock_phase_bit) begin
                data_out_lane_a <= pb_word[`ADCRO_WORD_BITS*2-1 -: 8];
                shift_reg       <= {pb_word[`ADCRO_WORD_BITS*2-9:0], 8'h00};
                bit_cnt_reg <= 6'd8;
                first_reg   <= 1'b0;
              end
            end else begin
              // other modes take a configuration frame
              state_reg <= ST_CFG;
            end
          end
        end
        ST_RUN: begin
          if (rise_ev)
            strobe_reg <= 1'b1;
          else if (fall_ev)
            strobe_reg <= 1'b0;
          strobe_out <= is_crt ? (rise_ev | (strobe_reg & ~fall_ev)) : 1'b0;
          // variants 01/11 launch at first clock edge
          if (shift_ev && bit_cnt_reg < total_bits) begin
            if (is_pb) begin
              data_out_lane_a <= shift_reg[31:24];
              shift_reg       <= {shift_reg[23:0], 8'h00};
              bit_cnt_reg     <= bit_cnt_reg + 6'd8;
            end else begin
              case (lanes)
                3'd2: data_out_lane_a <= {6'h00, shift_reg[31:30]};
                3'd4: data_out_lane_a <= {4'h0, shift_reg[31:28]};
                default: data_out_lane_a <= {7'h00, shift_reg[31]};
              endcase
              shift_reg   <= shift_reg << lanes;
              bit_cnt_reg <= bit_cnt_reg + {3'h0, lanes};
            end
            first_reg <= 1'b0;
          end
          // internal source stops itself after the word
          // Double rate ends low after its last launch: no extra pulse
          if (is_crt && !ext_src && bit_cnt_reg >= total_bits &&
              (fall_ev || output_protocol_sel == `ADCRO_PROTO_CRT_DDR))
            state_reg <= ST_DONE;
          if (cs_rise) begin
            state_reg          <= ST_IDLE;
            data_out_lane_a_oe <= 8'h00;
            strobe_out         <= 1'b0;
            strobe_reg         <= 1'b0;
            read_busy          <= 1'b0;
          end
        end
        ST_DONE: begin
          strobe_out <= 1'b0;
          strobe_reg <= 1'b0;
          if (cs_rise) begin
            state_reg          <= ST_IDLE;
            data_out_lane_a_oe <= 8'h00;
            read_busy          <= 1'b0;
          end
        end
        ST_CFG: begin
          // frame captured on rising serial clock
          if (sclk_rise && cmd_cnt_reg < 5'd`ADCRO_CMD_BITS) begin
            cmd_reg     <= {cmd_reg[14:0], sdi_s};
            cmd_cnt_reg <= cmd_cnt_reg + 5'h01;
          end
          if (cs_rise) begin
            state_reg <= ST_IDLE;
            read_busy <= 1'b0;
            if (cmd_cnt_reg == 5'd`ADCRO_CMD_BITS &&
                cmd_reg[15:12] == `ADCRO_CFG_OPC_WRITE) begin
              case (cmd_reg[11:8])
                `ADCRO_CFG_ADDR_PROTO: begin
                  clock_polarity_bit  <= cmd_reg[0];
                  clock_phase_bit     <= cmd_reg[1];
                  output_protocol_sel <= cmd_reg[4:2];
                end
                `ADCRO_CFG_ADDR_BUSW:  lane_count_sel <= cmd_reg[1:0];
                `ADCRO_CFG_ADDR_CRT:   retimer_clock_source_sel <= cmd_reg[0];
                `ADCRO_CFG_ADDR_OWORD: byte_format_sel <= cmd_reg[0];
                default: cmd_reg <= cmd_reg;
              endcase
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // adcro_readout

// *** rtl/adcro_defs.vh ***
// Shared constants for the converter read-out block
`ifndef ADCRO_DEFS_VH
`define ADCRO_DEFS_VH
`define ADCRO_PROTO_SPI_SDR     3'h0
`define ADCRO_PROTO_SPI_DDR     3'h1
`define ADCRO_PROTO_CRT_SDR     3'h2
`define ADCRO_PROTO_CRT_DDR     3'h3
`define ADCRO_PROTO_PB_BIT      2
`define ADCRO_LANES_ONE         2'h0
`define ADCRO_LANES_TWO         2'h1
`define ADCRO_LANES_FOUR        2'h2
`define ADCRO_CRT_SRC_EXT       1'h0
`define ADCRO_CRT_SRC_INT       1'h1
`define ADCRO_FMT_AB            1'h0
`define ADCRO_FMT_AA            1'h1
`define ADCRO_WORD_BITS         16
`define ADCRO_CMD_BITS          16
`define ADCRO_OSC_DIV           8'h04
`define ADCRO_CFG_OPC_WRITE     4'h1
`define ADCRO_CFG_ADDR_PROTO    4'h2
`define ADCRO_CFG_ADDR_BUSW     4'h3
`define ADCRO_CFG_ADDR_CRT      4'h4
`define ADCRO_CFG_ADDR_OWORD    4'h5
`define ADCRO_CFG_PROTO_RST     8'h00
`endif

// *** rtl/adcro_sync2.v ***
// Two-stage synchroniser for one pin input
`timescale 1ns/100ps
module adcro_sync2 (
  input  wire clk_sys,
  input  wire reset,
  input  wire pin_in,
  output reg  pin_sync
);
  reg meta_reg;

  always @(posedge clk_sys) begin
    if (reset) begin
      meta_reg <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end
endmodule // adcro_sync2

// *** rtl/adcro_osc_div.v ***
// Internal strobe oscillator: one-cycle enable pulses from a divider
`timescale 1ns/100ps
`include "adcro_defs.vh"
module adcro_osc_div #(
  parameter [7:0] DIV = `ADCRO_OSC_DIV
) (
  input  wire clk_sys,
  input  wire reset,
  input  wire run,
  output reg  tick
);
  reg [7:0] cnt_reg;

  always @(posedge clk_sys) begin
    if (reset || !run) begin
      cnt_reg <= 8'h00;
      tick    <= 1'b0;
    end else if (cnt_reg == DIV - 8'h01) begin
      cnt_reg <= 8'h00;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      tick    <= 1'b0;
    end
  end
endmodule // adcro_osc_div

// *** sim/adcro_monitor.sv ***
// Concurrent checks on the read-out port pins
`timescale 1ns/100ps
module adcro_monitor (
  input wire       clk_sys,
  input wire       reset,
  input wire       cs_n_pin,
  input wire [7:0] data_out_lane_a,
  input wire [7:0] data_out_lane_a_oe,
  input wire       strobe_out,
  input wire [2:0] output_protocol_sel,
  input wire [1:0] lane_count_sel,
  input wire       retimer_clock_source_sel,
  input wire       read_busy
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  wire       clock_retimer    = (output_protocol_sel[2:1] == 2'b01);
  wire       drv    = (data_out_lane_a_oe != 8'h00);
  wire [7:0] crt_oe = (lane_count_sel == 2'h0) ? 8'h01 : (lane_count_sel == 2'h1) ? 8'h03 : 8'h0f;
  idle_release_a: assert property (cs_n_pin [*6] |-> !drv && !strobe_out)
    else $error("lanes or strobe active with select high");
  busy_frame_a: assert property (!cs_n_pin [*6] |-> read_busy)
    else $error("select low but no frame in progress");
  crt_lanes_a: assert property (clock_retimer && drv |-> data_out_lane_a_oe == crt_oe)
    else $error("retimed lanes enabled beyond lane count");
  byte_lanes_a: assert property (output_protocol_sel[2] && drv |-> data_out_lane_a_oe == 8'hff)
    else $error("byte mode not driving all lanes");
  drive_start_a: assert property ($fell(cs_n_pin) && output_protocol_sel[2:1] != 2'b00
    |-> ##[1:6] drv)
    else $error("lanes not driven after select fall");
  strobe_mode_a: assert property (strobe_out |-> clock_retimer && read_busy)
    else $error("strobe outside a retimed frame");
  sdr_launch_a: assert property (clock_retimer && !output_protocol_sel[0] && drv && $past(drv)
    && $changed(data_out_lane_a & crt_oe) |-> strobe_out)
    else $error("single rate data changed with strobe low");
  cfg_lock_a: assert property ($past(output_protocol_sel[2:1]) != 2'b00
    |-> $stable(output_protocol_sel))
    else $error("protocol changed while in read mode");
  rst_default_a: assert property ($fell(reset) |-> output_protocol_sel == 3'h0
    && lane_count_sel == 2'h0 && !retimer_clock_source_sel)
    else $error("configuration not at default after reset");
endmodule // adcro_monitor
bind adcro_readout adcro_monitor i_adcro_monitor (
  .clk_sys(clk_sys), .reset(reset), .cs_n_pin(cs_n_pin), .data_out_lane_a(data_out_lane_a),
  .data_out_lane_a_oe(data_out_lane_a_oe), .strobe_out(strobe_out),
  .output_protocol_sel(output_protocol_sel), .lane_count_sel(lane_count_sel),
  .retimer_clock_source_sel(retimer_clock_source_sel), .read_busy(read_busy)
);

// *** sim/adcro_host_model.sv ***
// Host controller model: select, serial clock, command bits, lane capture
`timescale 1ns/100ps
module adcro_host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] data_out_lane_a,
  input  wire logic       strobe_out,
  output logic            cs_n_pin,
  output logic            sclk_pin,
  output logic            sdi_pin
);
  logic [15:0] cap_word;
  logic [31:0] cap_bytes;
  logic [7:0]  lane_mask;
  logic        str_q = 1'b0;
  logic        take = 1'b0;
  logic        ddr = 1'b0;
  int          lane_w = 1;
  int          cap_cnt = 0;
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    sdi_pin  = 1'b0;
  end
  // Capture after strobe edges
  // One clock of slack so launch and strobe may differ by a cycle
  always @(posedge clk_sys) begin
    str_q <= strobe_out;
    take  <= (strobe_out !== str_q) && (ddr || !strobe_out);
    if (take) begin
      cap_word <= (cap_word << lane_w) | {8'h00, data_out_lane_a & lane_mask};
      cap_cnt  <= cap_cnt + 1;
    end
  end
  // Framed clock idling at pol, command MSB first
  task automatic frame(input logic pol, input int hold, input int edges,
                       input logic [15:0] cmd, input logic lead, input logic pb);
    int e;
    @(negedge clk_sys);
    sclk_pin  = pol;
    sdi_pin   = cmd[15];
    cap_cnt   = 0;
    cap_bytes = 32'h0000_0000;
    @(negedge clk_sys);
    cs_n_pin = 1'b0;
    repeat (hold) @(negedge clk_sys);
    for (e = 1; e <= edges + 1; e++) begin
      // Sample bytes at the next launch edge: margin for pin sync delay
      if (pb && e > 1 && ((e - lead) % 2 == 0))
        cap_bytes = {cap_bytes[23:0], data_out_lane_a};
      if (e <= edges) begin
        sclk_pin = ~sclk_pin;
        repeat (4) @(negedge clk_sys);
        if (sclk_pin == pol) begin
          cmd     = cmd << 1;
          sdi_pin = cmd[15];
        end
      end
    end
    repeat (4) @(negedge clk_sys);
    cs_n_pin = 1'b1;
    repeat (6) @(negedge clk_sys);
  endtask
endmodule // adcro_host_model

// *** sim/adc_readout_retimed_and_byte_port_tb.sv ***
// Self-checking bench for the converter read-out port
`timescale 1ns/100ps
`include "adcro_defs.vh"
`define CHECK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module adc_readout_retimed_and_byte_port_tb;
  logic        clk_sys  = 1'b0;
  logic        reset    = 1'b1;
  logic [15:0] result_a = 16'hb4e1;
  logic [15:0] result_b = 16'h6c3a;
  logic [31:0] exp_b;
  wire         cs_n_pin, sclk_pin, sdi_pin, strobe_out, read_busy;
  wire  [7:0]  data_out_lane_a, data_out_lane_a_oe;
  wire  [2:0]  output_protocol_sel;
  wire  [1:0]  lane_count_sel;
  wire         retimer_clock_source_sel, clock_polarity_bit, clock_phase_bit, byte_format_sel;
  int          failures = 0;
  int          samples_checked = 0;
  int          w;
  always #12.5 clk_sys = ~clk_sys;
  adcro_readout i_adcro_readout (
    .clk_sys(clk_sys), .reset(reset), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .sdi_pin(sdi_pin), .result_a(result_a), .result_b(result_b),
    .data_out_lane_a(data_out_lane_a), .data_out_lane_a_oe(data_out_lane_a_oe),
    .strobe_out(strobe_out), .output_protocol_sel(output_protocol_sel),
    .lane_count_sel(lane_count_sel), .retimer_clock_source_sel(retimer_clock_source_sel),
    .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit),
    .byte_format_sel(byte_format_sel), .read_busy(read_busy));
  adcro_host_model i_adcro_host_model (
    .clk_sys(clk_sys), .data_out_lane_a(data_out_lane_a), .strobe_out(strobe_out),
    .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin));
  task end_sim;
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task rst;
    @(negedge clk_sys);
    reset = 1'b1;
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  task cfg(input logic [3:0] op, input logic [3:0] addr, input logic [7:0] data);
    i_adcro_host_model.frame(1'b0, 4, 32, {op, addr, data}, 1'b0, 1'b0);
  endtask
  initial begin
    rst();
    `CHECK("config after reset", 9'h000, {output_protocol_sel, lane_count_sel, retimer_clock_source_sel, clock_polarity_bit, clock_phase_bit, byte_format_sel})
    // Non-write opcode must leave the lane count alone
    cfg(4'h2, `ADCRO_CFG_ADDR_BUSW, 8'h02);
    `CHECK("refused opcode", 2'h0, lane_count_sel)
    for (int s = 0; s < 2; s++)
      for (int d = 0; d < 2; d++)
        for (int n = 0; n < 3; n++) begin
          rst();
          w = 1 << n;
          i_adcro_host_model.lane_w    = w;
          i_adcro_host_model.lane_mask = 8'((1 << w) - 1);
          i_adcro_host_model.ddr       = d[0];
          cfg(`ADCRO_CFG_OPC_WRITE, `ADCRO_CFG_ADDR_BUSW, 8'(n));
          cfg(`ADCRO_CFG_OPC_WRITE, `ADCRO_CFG_ADDR_CRT, 8'(s));
          // Protocol last: the field locks once a read mode is set
          cfg(`ADCRO_CFG_OPC_WRITE, `ADCRO_CFG_ADDR_PROTO, 8'((2 + d) << 2));
          `CHECK("protocol field", 3'(2 + d), output_protocol_sel)
          `CHECK("clock source", 1'(s), retimer_clock_source_sel)
          if (s == 1)
            i_adcro_host_model.frame(1'b0, 300, 0, 16'h0000, 1'b0, 1'b0);
          else
            i_adcro_host_model.frame(1'b0, 4, (2 - d) * 16 / w, 16'h0000, 1'b0, 1'b0);
          `CHECK("retimed word", result_a, i_adcro_host_model.cap_word)
          `CHECK("strobe launches", 16 / w, i_adcro_host_model.cap_cnt)
        end
    for (int v = 0; v < 4; v++)
      for (int f = 0; f < 2; f++) begin
        rst();
        cfg(`ADCRO_CFG_OPC_WRITE, `ADCRO_CFG_ADDR_OWORD, 8'(f));
        cfg(`ADCRO_CFG_OPC_WRITE, `ADCRO_CFG_ADDR_PROTO, {3'h0, 1'b1, v[1:0], v[1:0]});
        `CHECK("byte protocol", {1'b1, v[1:0]}, output_protocol_sel)
        i_adcro_host_model.frame(v[0], 4, 8, 16'h0000, v[1], 1'b1);
        exp_b = f ? {result_a, result_b}
                  : {result_a[15:8], result_b[15:8], result_a[7:0], result_b[7:0]};
        `CHECK("byte sequence", exp_b, i_adcro_host_model.cap_bytes)
      end
    end_sim();
  end
  // Whole run is about 10500 cycles
  initial begin
    repeat (40000) @(posedge clk_sys);
    failures++;
    end_sim();
  end
endmodule // adc_readout_retimed_and_byte_port_tb
